//--- include/axd_pkg.sv
package axd_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_NAME  = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_SETUP = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_POS   = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h10;
   // CTRL: bit0 addressing enable, bits 2:1 reply verbosity
   localparam int CTRL_MD_BIT = 0;
   localparam int CTRL_VB_LSB = 1;
   // SETUP: bit0 cw limit, bit1 ccw limit, bit2 home input
   localparam int SETUP_CW_BIT   = 0;
   localparam int SETUP_CCW_BIT  = 1;
   localparam int SETUP_HOME_BIT = 2;
   localparam logic       MD_RST    = 1'b1;
   localparam logic [1:0] VB_RST    = 2'h2;
   localparam logic [1:0] VB_ECHO   = 2'h0;
   localparam logic [7:0] NAME_RST  = 8'h31;
   localparam logic [2:0] SETUP_RST = 3'h7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] CH_LF    = 8'h0A;
   localparam logic [7:0] CH_STAR  = 8'h2A;
   localparam logic [7:0] CH_MINUS = 8'h2D;
   localparam logic [7:0] CH_0     = 8'h30;
   localparam logic [7:0] CH_9     = 8'h39;
   localparam logic [7:0] CH_HEXA  = 8'h37;
   localparam logic [15:0] CMD_MOVE    = 16'h4D52;
   localparam logic [15:0] CMD_PRINT   = 16'h5052;
   localparam logic [15:0] CMD_VERB    = 16'h454D;
   localparam logic [15:0] CMD_ADDR_EN = 16'h5059;
   localparam logic [15:0] CMD_HOME    = 16'h484D;
   localparam logic [3:0] PRT_LAST = 4'h9;
   localparam int CLK_NS       = 40;
   localparam int STEP_TIME_NS = 40000;
   localparam logic [15:0] STEP_CYC = 16'(STEP_TIME_NS / CLK_NS);
   localparam logic [2:0]  DECEL_STEPS = 3'h4;
   localparam logic [31:0] HOME_SPAN   = 32'h7FFFFFFF;
   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_BODY = 2'b01,
      P_EXEC = 2'b11,
      P_SKIP = 2'b10
   } axd_pstate_t;
endpackage

//--- design/axd_step_gen.sv
`timescale 1ns/10ps
module axd_step_gen
   import axd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic        start,
   input  wire logic        dir,
   input  wire logic [31:0] steps,
   input  wire logic        halt,
   output logic             step,
   output logic             busy,
   output logic             step_dir
);
   logic [15:0] tick;
   logic [31:0] left;
   logic [2:0]  dec;
   logic        stopping;
   logic        slow;

   assign slow = stopping | halt;

   // Stretches the step period on a halt so the motor ramps down
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         step     <= 1'b0;
         busy     <= 1'b0;
         step_dir <= 1'b0;
         tick     <= 16'h0000;
         left     <= 32'h00000000;
         dec      <= 3'h0;
         stopping <= 1'b0;
      end
      else if (ce)
      begin
         step <= 1'b0;
         if (!busy)
         begin
            if (start && steps != 32'h00000000)
            begin
               busy     <= 1'b1;
               left     <= steps;
               step_dir <= dir;
               tick     <= STEP_CYC - 16'h0001;
               dec      <= 3'h0;
               stopping <= 1'b0;
            end
         end
         else
         begin
            if (halt)
               stopping <= 1'b1;
            if (tick == 16'h0000)
            begin
               step <= 1'b1;
               left <= left - 32'h00000001;
               if (slow)
               begin
                  dec  <= dec + 3'h1;
                  tick <= 16'(STEP_CYC << (dec + 3'h1)) - 16'h0001;
               end
               else
                  tick <= STEP_CYC - 16'h0001;
               if (left == 32'h00000001 || (slow && dec == DECEL_STEPS - 3'h1))
                  busy <= 1'b0;
            end
            else
               tick <= tick - 16'h0001;
         end
      end
   end
endmodule

//--- design/axd_dispatch.sv
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module axd_dispatch
   import axd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              ce,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   input  wire logic              rx_valid,
   input  wire logic [7:0]        rx_data,
   output logic                   tx_valid,
   output logic [7:0]             tx_data,
   input  wire logic              tx_ready,
   input  wire logic              lim_cw_in,
   input  wire logic              lim_ccw_in,
   input  wire logic              optical_home_sensor,
   output logic                   step_out,
   output logic                   dir_out,
   output logic                   moving
);
   axd_pstate_t pstate;
   logic        multidrop_addressing_enable;
   logic [1:0]  reply_verbosity_setting;
   logic [7:0]  axis_name_string;
   logic        input_one_setup, input_two_setup, input_three_setup;
   logic [7:0]  c0, c1;
   logic [1:0]  cnt;
   logic [31:0] arg, pos, snap;
   logic        neg, armed, homing, zero_pend, seen;
   logic [3:0]  prt_idx;
   logic        aw_got, w_got;
   logic [ADDR_W-1:0] waddr;
   logic [31:0] wdat;
   logic [3:0]  wstb;
   logic        exec, is_digit, tx_free, echo_on, echo_req, wr_do, wr_map;
   logic [15:0] cmd;
   logic [7:0]  term;
   logic        cw_act, ccw_act, home_act, mv_req, hm_req, req_dir, blocked, go, halt;
   logic [31:0] go_steps, rd_mux;

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   function automatic logic [7:0] hex_ch(input logic [3:0] n);
      hex_ch = (n < 4'hA) ? CH_0 + {4'h0, n} : CH_HEXA + {4'h0, n};
   endfunction

   assign exec     = (pstate == P_EXEC);
   assign cmd      = {c0, c1};
   assign is_digit = (rx_data >= CH_0) && (rx_data <= CH_9);
   assign term     = multidrop_addressing_enable ? CH_LF : CH_CR;
   assign tx_free  = !tx_valid || tx_ready;
   assign echo_on  = !multidrop_addressing_enable
                     || (reply_verbosity_setting == VB_ECHO && pstate == P_BODY);
   assign echo_req = rx_valid && echo_on;
   assign wr_do    = aw_got && w_got && !s_axi_bvalid;
   assign wr_map   = (waddr == ADDR_CTRL) || (waddr == ADDR_NAME) || (waddr == ADDR_SETUP)
                     || (waddr == ADDR_POS) || (waddr == ADDR_STAT);

   // Command parser; a byte arriving in the execute cycle is dropped
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pstate <= P_IDLE;
         c0     <= 8'h00;
         c1     <= 8'h00;
         cnt    <= 2'h0;
         arg    <= 32'h00000000;
         neg    <= 1'b0;
         armed  <= 1'b0;
      end
      else if (ce)
      begin
         unique case (pstate)
            P_EXEC: pstate <= P_IDLE;
            P_IDLE:
               if (rx_valid)
               begin
                  if (multidrop_addressing_enable)
                  begin
                     if (!armed)
                     begin
                        if (rx_data == CH_LF)
                           armed <= 1'b1;
                     end
                     else if (rx_data == axis_name_string || rx_data == CH_STAR)
                     begin
                        pstate <= P_BODY;
                        cnt    <= 2'h0;
                        arg    <= 32'h00000000;
                        neg    <= 1'b0;
                     end
                     else if (rx_data != CH_LF)
                        pstate <= P_SKIP;
                  end
                  else if (rx_data != CH_CR)
                  begin
                     c0     <= rx_data;
                     cnt    <= 2'h1;
                     arg    <= 32'h00000000;
                     neg    <= 1'b0;
                     pstate <= P_BODY;
                  end
               end
            P_BODY:
               if (rx_valid)
               begin
                  if (rx_data == term)
                     pstate <= P_EXEC;
                  else if (cnt == 2'h0)
                  begin
                     c0  <= rx_data;
                     cnt <= 2'h1;
                  end
                  else if (cnt == 2'h1)
                  begin
                     c1  <= rx_data;
                     cnt <= 2'h2;
                  end
                  else if (rx_data == CH_MINUS)
                     neg <= 1'b1;
                  else if (is_digit)
                     arg <= 32'(arg * 32'd10) + {28'h0000000, rx_data[3:0]};
               end
            P_SKIP:
               if (rx_valid && rx_data == CH_LF)
                  pstate <= P_IDLE;
         endcase
         if (!multidrop_addressing_enable)
            armed <= 1'b0;
      end
   end

   // Configuration, written by software and by executed commands
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         multidrop_addressing_enable <= MD_RST;
         reply_verbosity_setting     <= VB_RST;
         axis_name_string            <= NAME_RST;
         {input_three_setup, input_two_setup, input_one_setup} <= SETUP_RST;
      end
      else if (ce)
      begin
         if (wr_do && wstb[0])
         begin
            if (waddr == ADDR_CTRL)
            begin
               multidrop_addressing_enable <= wdat[CTRL_MD_BIT];
               reply_verbosity_setting     <= wdat[CTRL_VB_LSB +: 2];
            end
            if (waddr == ADDR_NAME)
               axis_name_string <= wdat[7:0];
            if (waddr == ADDR_SETUP)
            begin
               input_one_setup   <= wdat[SETUP_CW_BIT];
               input_two_setup   <= wdat[SETUP_CCW_BIT];
               input_three_setup <= wdat[SETUP_HOME_BIT];
            end
         end
         if (exec && cmd == CMD_VERB)
            reply_verbosity_setting <= arg[1:0];
         if (exec && cmd == CMD_ADDR_EN)
            multidrop_addressing_enable <= arg[0];
      end
   end

   // Replies: print output first, then echo; echo is lost while busy
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         tx_valid <= 1'b0;
         tx_data  <= 8'h00;
         prt_idx  <= 4'h0;
         snap     <= 32'h00000000;
      end
      else if (ce)
      begin
         if (tx_valid && tx_ready)
            tx_valid <= 1'b0;
         if (tx_free)
         begin
            if (prt_idx == PRT_LAST)
            begin
               tx_data  <= CH_CR;
               tx_valid <= 1'b1;
               prt_idx  <= 4'h0;
            end
            else if (prt_idx != 4'h0)
            begin
               tx_data  <= hex_ch(snap[31:28]);
               snap     <= {snap[27:0], 4'h0};
               prt_idx  <= prt_idx + 4'h1;
               tx_valid <= 1'b1;
            end
            else if (echo_req)
            begin
               tx_data  <= rx_data;
               tx_valid <= 1'b1;
            end
         end
         if (exec && cmd == CMD_PRINT)
         begin
            prt_idx <= 4'h1;
            snap    <= pos;
         end
      end
   end

   // Switch inputs read high when open or unwired
   assign cw_act   = input_one_setup & lim_cw_in;
   assign ccw_act  = input_two_setup & lim_ccw_in;
   assign home_act = input_three_setup & optical_home_sensor;
   assign mv_req   = exec && cmd == CMD_MOVE;
   assign hm_req   = exec && cmd == CMD_HOME;
   assign req_dir  = hm_req ? 1'b0 : !neg;
   assign blocked  = req_dir ? cw_act : ccw_act;
   assign go       = (mv_req || hm_req) && !moving && !blocked;
   assign go_steps = hm_req ? HOME_SPAN : arg;
   assign halt     = moving && ((dir_out && cw_act) || (!dir_out && ccw_act)
                                || (homing && home_act));

   axd_step_gen u_step (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .start    (go),
      .dir      (req_dir),
      .steps    (go_steps),
      .halt     (halt),
      .step     (step_out),
      .busy     (moving),
      .step_dir (dir_out)
   );

   // Position count and homing
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pos       <= 32'h00000000;
         homing    <= 1'b0;
         zero_pend <= 1'b0;
      end
      else if (ce)
      begin
         if (step_out)
            pos <= dir_out ? pos + 32'h00000001 : pos - 32'h00000001;
         if (go && hm_req)
            homing <= 1'b1;
         if (homing && home_act)
            zero_pend <= 1'b1;
         if (homing && !moving && !go)
         begin
            homing    <= 1'b0;
            zero_pend <= 1'b0;
            if (zero_pend || home_act)
               pos <= 32'h00000000;
         end
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         waddr         <= '0;
         wdat          <= 32'h00000000;
         wstb          <= 4'h0;
      end
      else if (ce)
      begin
         if (!aw_got && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
         if (!w_got && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got        <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr         <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got        <= 1'b1;
            s_axi_wready <= 1'b0;
            wdat         <= s_axi_wdata;
            wstb         <= s_axi_wstrb;
         end
         if (wr_do)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_comb
   begin
      rd_mux = 32'h00000000;
      unique case (s_axi_araddr)
         ADDR_CTRL:  rd_mux = {29'h0, reply_verbosity_setting, multidrop_addressing_enable};
         ADDR_NAME:  rd_mux = {24'h0, axis_name_string};
         ADDR_SETUP: rd_mux = {29'h0, input_three_setup, input_two_setup, input_one_setup};
         ADDR_POS:   rd_mux = pos;
         ADDR_STAT:  rd_mux = {26'h0, homing, moving, armed, home_act, ccw_act, cw_act};
         default:    rd_mux = 32'h00000000;
      endcase
   end

   // AXI4-Lite read channel
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (!s_axi_rvalid)
            s_axi_arready <= 1'b1;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= (s_axi_araddr <= ADDR_STAT && s_axi_araddr[1:0] == 2'h0)
                             ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         seen <= 1'b0;
      else
         seen <= 1'b1;
   end

   property p_echo;
      ce && rx_valid && !multidrop_addressing_enable && tx_free && prt_idx == 4'h0
      |=> tx_valid && tx_data == $past(rx_data);
   endproperty
   a_echo: assert property (p_echo) else $error("character not echoed");
   property p_cr_exec;
      ce && rx_valid && !multidrop_addressing_enable && pstate == P_BODY && rx_data == CH_CR
      |=> pstate == P_EXEC ##1 pstate == P_IDLE || !ce;
   endproperty
   a_cr_exec: assert property (p_cr_exec) else $error("cr did not execute");
   property p_foreign;
      ce && rx_valid && multidrop_addressing_enable && armed && pstate == P_IDLE
      && rx_data != axis_name_string && rx_data != CH_STAR && rx_data != CH_LF
      |=> pstate == P_SKIP && !tx_valid;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign command taken");
   property p_lf_exec;
      ce && rx_valid && multidrop_addressing_enable && pstate == P_BODY && rx_data == CH_LF
      |=> exec;
   endproperty
   a_lf_exec: assert property (p_lf_exec) else $error("lf did not execute");
   property p_global;
      ce && rx_valid && multidrop_addressing_enable && armed && pstate == P_IDLE
      && rx_data == CH_STAR |=> pstate == P_BODY;
   endproperty
   a_global: assert property (p_global) else $error("global name refused");
   property p_defaults;
      !seen |-> multidrop_addressing_enable == MD_RST && reply_verbosity_setting == VB_RST
                && axis_name_string == NAME_RST && !armed;
   endproperty
   a_defaults: assert property (p_defaults) else $error("bad reset values");
   property p_quiet;
      ce && !tx_valid && prt_idx == 4'h0 && multidrop_addressing_enable
      && reply_verbosity_setting == VB_RST |=> !tx_valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("reply without print");
   property p_verb0;
      ce && exec && cmd == CMD_VERB && arg == 32'h00000000 |=> reply_verbosity_setting == VB_ECHO;
   endproperty
   a_verb0: assert property (p_verb0) else $error("verbosity not zeroed");
   property p_addr_off;
      ce && exec && cmd == CMD_ADDR_EN && arg == 32'h00000000
      |=> !multidrop_addressing_enable ##1 !armed;
   endproperty
   a_addr_off: assert property (p_addr_off) else $error("addressing not left");
   property p_blocked;
      ce && mv_req && !moving && (neg ? ccw_act : cw_act) |=> !moving [*2];
   endproperty
   a_blocked: assert property (p_blocked) else $error("move into active limit");
   property p_decel;
      ce && halt && !$past(halt) |=> moving;
   endproperty
   a_decel: assert property (p_decel) else $error("abrupt stop on limit");
   property p_home;
      ce && homing && !moving && !go && zero_pend |=> pos == 32'h00000000 && !homing;
   endproperty
   a_home: assert property (p_home) else $error("home did not zero");

   c_single_exec: cover property (!multidrop_addressing_enable && exec);
   c_print_end: cover property (ce && tx_free && prt_idx == PRT_LAST);
   c_skip: cover property (pstate == P_SKIP ##1 pstate == P_IDLE);
   c_decel: cover property (halt ##1 moving && step_out);
endmodule

//--- tb/axd_host_model.sv
`timescale 1ns/10ps
module axd_host_model
   import axd_pkg::*;
(
   input  wire logic       clk,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready
);
   byte unsigned got[$];
   initial
   begin
      rx_valid = 1'b0;
      rx_data  = 8'h00;
      tx_ready = 1'b1;
   end
   // Stalls replies at random and keeps every byte taken
   always @(posedge clk)
   begin
      tx_ready <= 1'($urandom_range(0, 2) != 0);
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
   end
   // Waits for a free reply path so an echo is never dropped
   task automatic send(input logic [7:0] b);
      @(posedge clk);
      while (tx_valid)
         @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= b;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~b;
      repeat (4) @(posedge clk);
   endtask
endmodule

//--- tb/axd_dispatch_tb_top.sv
`timescale 1ns/10ps
module axd_dispatch_tb_top
   import axd_pkg::*;
;
   logic        clk, sys_rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, rx_valid, tx_valid, tx_ready, lim_cw_in, lim_ccw_in;
   logic        optical_home_sensor, step_out, dir_out, moving;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, tx_data;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          err_total = 0;
   int          n_checks = 0;
   int          n_step = 0;
   axd_dispatch axd_dispatch_i (.clk, .sys_rst, .ce, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .rx_valid, .rx_data,
      .tx_valid, .tx_data, .tx_ready, .lim_cw_in, .lim_ccw_in, .optical_home_sensor,
      .step_out, .dir_out, .moving);
   axd_host_model axd_host_model_i (.clk, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
      if (step_out)
         n_step++;
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_txt(input string e, input string g);
      n_checks++;
      if (g != e)
      begin
         err_total++;
         $display("MISMATCH reply expected %p seen %p", e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      s_axi_awaddr <= a;
      s_axi_wdata  <= d;
      do
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      s_axi_araddr <= a;
      do
      begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   // Sends a line, lets the replies drain, compares unless told "?"
   task automatic cmd(input string s, input string e);
      string g = "";
      foreach (s[k]) axd_host_model_i.send(s[k]);
      repeat (300) @(posedge clk);
      foreach (axd_host_model_i.got[k]) g = {g, string'(axd_host_model_i.got[k])};
      axd_host_model_i.got.delete();
      if (e != "?")
         chk_txt(e, g);
   endtask
   function automatic string hex8(input logic [31:0] v);
      string t = $sformatf("%h", v);
      return {t.toupper(), "\r"};
   endfunction
   task automatic pos_is(input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(ADDR_POS, d, r);
      chk("position", e, d);
   endtask
   initial
   begin
      #4000000;
      err_total++;
      wrap_up();
   end
   initial
   begin
      logic [31:0] d, m;
      int          base_steps;
      logic [1:0]  r;
      void'($urandom(32'h3793CB65));
      {sys_rst, ce, s_axi_wstrb} = {2'h3, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {lim_cw_in, lim_ccw_in, optical_home_sensor} = 3'h0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(ADDR_CTRL, d, r);
      chk("ctrl reset", {29'h0, VB_RST, MD_RST}, d);
      rd(ADDR_NAME, d, r);
      chk("name reset", 32'h31, d);
      rd(ADDR_SETUP, d, r);
      chk("setup reset", 32'h7, d);
      rd(8'h14, d, r);
      chk("unmapped resp", RESP_SLVERR, r);
      $display("register test done");
      cmd("1PR P\n", "");
      cmd("\n", "");
      cmd("1PR P\n", hex8(0));
      cmd("2PR P\n", "");
      m = $urandom_range(3, 6);
      cmd($sformatf("*MR %0d\n", m), "");
      repeat (7000) @(posedge clk);
      chk("step pulses", m, n_step);
      cmd("*PR P\n", hex8(m));
      $display("addressed test done");
      lim_cw_in <= 1'b1;
      cmd("1MR 2\n", "");
      repeat (3000) @(posedge clk);
      pos_is(m);
      cmd("1MR -2\n", "");
      // Clock enable low must freeze the move that has just started
      ce <= 1'b0;
      repeat (3000) @(posedge clk);
      ce <= 1'b1;
      pos_is(m);
      repeat (3000) @(posedge clk);
      pos_is(m - 2);
      chk("direction", 32'h0, dir_out);
      lim_ccw_in <= 1'b1;
      cmd("1MR -1\n", "");
      cmd("1MR 1\n", "");
      repeat (3000) @(posedge clk);
      pos_is(m - 2);
      {lim_cw_in, lim_ccw_in} <= 2'h0;
      base_steps = n_step;
      cmd("1HM\n", "");
      repeat (1500) @(posedge clk);
      optical_home_sensor <= 1'b1;
      repeat (40000) @(posedge clk);
      pos_is(0);
      chk("moving", 0, moving);
      chk("decel steps", 32'(DECEL_STEPS) + 32'd1, n_step - base_steps);
      optical_home_sensor <= 1'b0;
      $display("motion test done");
      cmd("1EM=0\n", "");
      cmd("1PY=0\n", "PY=0\n");
      rd(ADDR_CTRL, d, r);
      chk("ctrl by command", 32'h0, d);
      cmd("PR P\r", {"PR P\r", hex8(0)});
      wr(ADDR_CTRL, 32'h5, r);
      chk("write resp", RESP_OKAY, r);
      cmd("\n", "");
      cmd("1PR P\n", hex8(0));
      $display("single axis test done");
      wrap_up();
   end
endmodule
